// *** src/sldc_regs.vh ***
// sldc_regs.vh: constants shared by the segment lcd drive block.
// assumes it is included by bare name and holds definitions only.
`ifndef SLDC_REGS_VH
`define SLDC_REGS_VH

// drive level codes presented on each common and segment output
`define SLDC_LVL_GND      3'h0
`define SLDC_LVL_MID_LO   3'h1
`define SLDC_LVL_MID_HI   3'h2
`define SLDC_LVL_HI       3'h3
`define SLDC_LVL_MID      3'h4

// duty codes on {duty_select_hi, duty_select_lo}
`define SLDC_DUTY_STATIC  2'h0
`define SLDC_DUTY_HALF    2'h1
`define SLDC_DUTY_THIRD   2'h2
`define SLDC_DUTY_QUARTER 2'h3

// operating ticks per common slot at quarter duty, per clock path
`define SLDC_SLOT_SYS     10'h080
`define SLDC_SLOT_SUB     10'h040

// frame clock select: bit 3 low picks the subclock path
`define SLDC_FCS_SYS_BIT  3

// reset values
`define SLDC_RST_ALT      1'h0
`define SLDC_RST_ROW      2'h0
`define SLDC_RST_TICKS    10'h000
`define SLDC_RST_BYTE     8'h00

// geometry
`define SLDC_NUM_SEG      32
`define SLDC_NUM_COM      4
`define SLDC_RAM_BYTES    16

`endif

// *** src/sldc_clk_sel.v ***
// sldc_clk_sel: picks and divides the operating clock of the display.
// assumes sys_clock_run and sub_clock_tick are synchronous to clk.
`timescale 1ns/1ps
`include "sldc_regs.vh"

module sldc_clk_sel (
  input  wire       clk,
  input  wire       rst,
  input  wire       enable,
  input  wire [3:0] frame_clock_select,
  input  wire       sys_clock_run,
  input  wire       sub_clock_tick,
  output wire       op_tick,
  output wire       sub_path,
  output wire       clock_present
);

  reg  [7:0] sys_cnt_r;
  reg  [1:0] sub_cnt_r;
  wire [8:0] sys_mask9;
  wire [7:0] sys_mask;
  wire [1:0] sub_mask;
  wire       sys_tick;
  wire       sub_tick;

  assign sub_path = ~frame_clock_select[`SLDC_FCS_SYS_BIT];

  // system path divides by 2 up to 256; mask has k low ones for 2^k
  assign sys_mask9 = (9'h002 << frame_clock_select[2:0]) - 9'h001;
  assign sys_mask  = sys_mask9[7:0];
  // subclock path divides by 1, 2 or 4
  assign sub_mask  = frame_clock_select[1] ? 2'h3 :
                     (frame_clock_select[0] ? 2'h1 : 2'h0);

  // no system clock means no ticks at all on that path
  assign sys_tick = sys_clock_run & ((sys_cnt_r & sys_mask) == sys_mask);
  assign sub_tick = sub_clock_tick & ((sub_cnt_r & sub_mask) == sub_mask);

  // disabled in standby or module standby, so the subclock never reaches us
  assign op_tick       = enable & (sub_path ? sub_tick : sys_tick);
  assign clock_present = sub_path | sys_clock_run;

  // prescalers restart from zero whenever the display is off
  always @(posedge clk) begin
    if (rst || !enable) begin
      sys_cnt_r <= 8'h00;
      sub_cnt_r <= 2'h0;
    end else begin
      if (sys_clock_run)
        sys_cnt_r <= sys_cnt_r + 8'h01;
      if (sub_clock_tick)
        sub_cnt_r <= sub_cnt_r + 2'h1;
    end
  end

endmodule

// *** src/sldc_drive.v ***
// sldc_drive: segment lcd controller core, scan timing and drive levels.
// assumes all inputs are synchronous to CLK and the panel decodes the
// three-bit level code of each output into its physical voltage.
//
// Functional notes
// - boosted static: all four commons identical
// - boosted half duty: commons paired 1-2, 3-4
// - duty field picks static, half, third, quarter
// - only selected segment drivers are enabled
// - byte or word ram writes; duty-dependent mapping
// - scanning starts by itself once activated
// - waveform select chooses A or B alternation
// - level table per duty, data and alternation
// - absent system clock halts non-subclock display
// - reset or activate low stops the display
// - standby stops display and drive power
// - subclock gated from block in standby
// - module standby stops the display but not drive power
// - waveform select 0 is A, 1 is B
`timescale 1ns/1ps
`include "sldc_regs.vh"

module sldc_drive (
  input  wire        CLK,
  input  wire        RST,
  input  wire        COMMON_DRIVE_BOOST,
  input  wire        DUTY_SELECT_HI,
  input  wire        DUTY_SELECT_LO,
  input  wire [3:0]  SEGMENT_SELECT,
  input  wire [3:0]  FRAME_CLOCK_SELECT,
  input  wire        WAVEFORM_TYPE_SELECT,
  input  wire        DISPLAY_ACTIVATE,
  input  wire        DISPLAY_DATA_SHOW,
  input  wire        DRIVE_POWER_SWITCH,
  input  wire        SYS_CLOCK_RUN,
  input  wire        SUB_CLOCK_TICK,
  input  wire        STANDBY_MODE,
  input  wire        MODULE_STANDBY,
  input  wire        RAM_WRITE,
  input  wire        RAM_WORD,
  input  wire [3:0]  RAM_ADDR,
  input  wire [15:0] RAM_WDATA,
  output wire [15:0] RAM_RDATA,
  output wire [11:0] COM_LEVEL,
  output wire [3:0]  COM_DRIVE_EN,
  output wire [95:0] SEG_LEVEL,
  output wire [31:0] SEG_DRIVE_EN,
  output wire        ALTERNATION,
  output wire        DRIVE_POWER_ON,
  output wire        DISPLAY_RUNNING
);

  // display ram, one byte per address
  reg  [7:0]  ram_r [0:`SLDC_RAM_BYTES-1];
  reg  [15:0] rdata_r;

  // scan state
  reg  [9:0]  ticks_r;
  reg  [1:0]  row_r;
  reg         alt_r;
  reg  [9:0]  ticks_nxt;
  reg  [1:0]  row_nxt;
  reg         alt_nxt;

  // registered outputs
  reg  [11:0] com_level_r;
  reg  [3:0]  com_en_r;
  reg  [95:0] seg_level_r;
  reg  [31:0] seg_en_r;
  reg         power_r;
  reg         running_r;

  wire [11:0] com_level_nxt;
  wire [3:0]  com_en_nxt;
  wire [95:0] seg_level_nxt;
  wire [31:0] seg_en_nxt;

  wire [1:0]  duty;
  wire        disp_on;
  wire        op_tick;
  wire        sub_path;
  wire        clock_present;
  wire [1:0]  slot_shift;
  wire [9:0]  slot_base;
  wire [9:0]  slot_len;
  wire [9:0]  slot_last;
  wire        slot_end;
  wire        frame_end;
  wire        boost_pair;

  integer     i;

  // ram bit holding segment seg in common row row, per duty
  function [6:0] sldc_bit_index;
    input [4:0] seg;
    input [1:0] row;
    input [1:0] dty;
    begin
      if (dty == `SLDC_DUTY_STATIC)
        sldc_bit_index = {2'h0, seg};
      else if (dty == `SLDC_DUTY_HALF)
        sldc_bit_index = {1'h0, seg, row[0]};
      else
        sldc_bit_index = {seg, row};
    end
  endfunction

  // drive level from data, alternation and duty for either pin kind
  function [2:0] sldc_level;
    input       is_com;
    input       d;
    input       m;
    input [1:0] dty;
    reg   [1:0] dm;
    begin
      dm = {d, m};
      if (dty == `SLDC_DUTY_STATIC && is_com) begin
        sldc_level = m ? `SLDC_LVL_GND : `SLDC_LVL_HI;
      end else if (dty == `SLDC_DUTY_HALF && is_com) begin
        if (!d)
          sldc_level = `SLDC_LVL_MID;
        else
          sldc_level = m ? `SLDC_LVL_GND : `SLDC_LVL_HI;
      end else if (dty == `SLDC_DUTY_STATIC || dty == `SLDC_DUTY_HALF) begin
        sldc_level = (d ^ m) ? `SLDC_LVL_GND : `SLDC_LVL_HI;
      end else if (is_com) begin
        case (dm)
          2'h0:    sldc_level = `SLDC_LVL_MID_LO;
          2'h1:    sldc_level = `SLDC_LVL_MID_HI;
          2'h2:    sldc_level = `SLDC_LVL_HI;
          default: sldc_level = `SLDC_LVL_GND;
        endcase
      end else begin
        case (dm)
          2'h0:    sldc_level = `SLDC_LVL_MID_HI;
          2'h1:    sldc_level = `SLDC_LVL_MID_LO;
          2'h2:    sldc_level = `SLDC_LVL_GND;
          default: sldc_level = `SLDC_LVL_HI;
        endcase
      end
    end
  endfunction

  assign duty = {DUTY_SELECT_HI, DUTY_SELECT_LO};

  // the block runs only when activated and neither standby is in force
  assign disp_on = DISPLAY_ACTIVATE & ~STANDBY_MODE & ~MODULE_STANDBY;

  sldc_clk_sel u_clk_sel (
    .clk                (CLK),
    .rst                (RST),
    .enable             (disp_on),
    .frame_clock_select (FRAME_CLOCK_SELECT),
    .sys_clock_run      (SYS_CLOCK_RUN),
    .sub_clock_tick     (SUB_CLOCK_TICK),
    .op_tick            (op_tick),
    .sub_path           (sub_path),
    .clock_present      (clock_present)
  );

  // slot length: fewer commons means longer slots, same frame ticks;
  // third duty keeps quarter-duty slots (128 or 64 ticks) so its frame runs 4/3 faster
  assign slot_shift = (duty == `SLDC_DUTY_STATIC) ? 2'h2 :
                      ((duty == `SLDC_DUTY_HALF) ? 2'h1 : 2'h0);
  assign slot_base  = sub_path ? `SLDC_SLOT_SUB : `SLDC_SLOT_SYS;
  assign slot_len   = slot_base << slot_shift;
  assign slot_last  = slot_len - 10'h001;
  assign slot_end   = op_tick && (ticks_r >= slot_last);
  // last row index equals the duty code; >= covers a duty change mid-frame
  assign frame_end  = slot_end && (row_r >= duty);

  // scan sequencer; no start command, a tick alone advances it
  always @* begin
    ticks_nxt = ticks_r;
    row_nxt   = row_r;
    alt_nxt   = alt_r;
    if (op_tick) begin
      if (slot_end) begin
        ticks_nxt = `SLDC_RST_TICKS;
        row_nxt   = frame_end ? `SLDC_RST_ROW : row_r + 2'h1;
      end else begin
        ticks_nxt = ticks_r + 10'h001;
      end
      // A flips once per frame; B flips every slot for finer balance
      if (!WAVEFORM_TYPE_SELECT) begin
        if (frame_end)
          alt_nxt = ~alt_r;
      end else if (slot_end) begin
        alt_nxt = ~alt_r;
      end
    end
  end

  // a stopped display restarts from the first row of a fresh frame;
  // a missing clock only freezes the scan, which is why low-power
  // modes need a subclock source to avoid dc on the glass
  always @(posedge CLK) begin
    if (RST || !disp_on) begin
      ticks_r <= `SLDC_RST_TICKS;
      row_r   <= `SLDC_RST_ROW;
      alt_r   <= `SLDC_RST_ALT;
    end else begin
      ticks_r <= ticks_nxt;
      row_r   <= row_nxt;
      alt_r   <= alt_nxt;
    end
  end

  // ram writes: word puts the high byte at the even address
  always @(posedge CLK) begin
    if (RST) begin
      for (i = 0; i < `SLDC_RAM_BYTES; i = i + 1)
        ram_r[i] <= `SLDC_RST_BYTE;
    end else if (RAM_WRITE) begin
      if (RAM_WORD) begin
        ram_r[{RAM_ADDR[3:1], 1'b0}] <= RAM_WDATA[15:8];
        ram_r[{RAM_ADDR[3:1], 1'b1}] <= RAM_WDATA[7:0];
      end else begin
        ram_r[RAM_ADDR] <= RAM_WDATA[7:0];
      end
    end
  end

  // readback of the addressed word, one cycle after the address
  always @(posedge CLK) begin
    if (RST)
      rdata_r <= 16'h0000;
    else
      rdata_r <= {ram_r[{RAM_ADDR[3:1], 1'b0}], ram_r[{RAM_ADDR[3:1], 1'b1}]};
  end

  // boost only means something at static and half duty
  assign boost_pair = COMMON_DRIVE_BOOST &&
                      (duty == `SLDC_DUTY_STATIC || duty == `SLDC_DUTY_HALF);

  genvar g;

  // common pins: map each physical pin to a logical common row
  generate
    for (g = 0; g < `SLDC_NUM_COM; g = g + 1) begin : com_gen
      localparam [1:0] PIN = g;
      wire [1:0] lidx;
      wire       sel;
      assign lidx = !boost_pair ? PIN :
                    ((duty == `SLDC_DUTY_STATIC) ? 2'h0 :
                     {1'b0, PIN[1]});
      assign sel  = (lidx == row_r);
      assign com_en_nxt[g] = boost_pair | (PIN <= duty);
      assign com_level_nxt[3*g+2:3*g] = sldc_level(1'b1, sel, alt_r, duty);
    end
  endgenerate

  // segment pins: enabled four at a time by the segment select field
  generate
    for (g = 0; g < `SLDC_NUM_SEG; g = g + 1) begin : seg_gen
      localparam [4:0] SEG_ID = g;
      wire [6:0] bi;
      wire       d;
      assign bi = sldc_bit_index(SEG_ID, row_r, duty);
      // blanking forces unlit data without touching ram
      assign d  = DISPLAY_DATA_SHOW & ram_r[bi[6:3]][bi[2:0]];
      assign seg_en_nxt[g] = ({1'b0, SEG_ID[4:2]} < SEGMENT_SELECT);
      assign seg_level_nxt[3*g+2:3*g] = sldc_level(1'b0, d, alt_r, duty);
    end
  endgenerate

  // output stage; stopped display grounds everything and drops enables
  always @(posedge CLK) begin
    if (RST || !disp_on) begin
      com_level_r <= 12'h000;
      com_en_r    <= 4'h0;
      seg_level_r <= 96'h0;
      seg_en_r    <= 32'h00000000;
    end else begin
      com_level_r <= com_level_nxt;
      com_en_r    <= com_en_nxt;
      seg_level_r <= seg_level_nxt;
      seg_en_r    <= seg_en_nxt;
    end
  end

  // drive supply follows the switch only while activated and not in standby
  always @(posedge CLK) begin
    if (RST) begin
      power_r   <= 1'b0;
      running_r <= 1'b0;
    end else begin
      power_r   <= DRIVE_POWER_SWITCH & DISPLAY_ACTIVATE & ~STANDBY_MODE;
      running_r <= disp_on & clock_present;
    end
  end

  assign RAM_RDATA       = rdata_r;
  assign COM_LEVEL       = com_level_r;
  assign COM_DRIVE_EN    = com_en_r;
  assign SEG_LEVEL       = seg_level_r;
  assign SEG_DRIVE_EN    = seg_en_r;
  assign ALTERNATION     = alt_r;
  assign DRIVE_POWER_ON  = power_r;
  assign DISPLAY_RUNNING = running_r;

endmodule

// *** test/sldc_drive_properties.sv ***
// sldc_drive_properties: timing checks on the ports of the lcd drive block.
// assumes it is bound onto sldc_drive and every input matches a port name.
`timescale 1ns/1ps

module sldc_drive_properties (
  input wire        CLK,
  input wire        RST,
  input wire        COMMON_DRIVE_BOOST,
  input wire        DUTY_SELECT_HI,
  input wire        DUTY_SELECT_LO,
  input wire [3:0]  SEGMENT_SELECT,
  input wire [3:0]  FRAME_CLOCK_SELECT,
  input wire        DISPLAY_ACTIVATE,
  input wire        SYS_CLOCK_RUN,
  input wire        STANDBY_MODE,
  input wire        MODULE_STANDBY,
  input wire [11:0] COM_LEVEL,
  input wire [31:0] SEG_DRIVE_EN,
  input wire        ALTERNATION,
  input wire        DRIVE_POWER_ON,
  input wire        DISPLAY_RUNNING
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  // config decode; outputs are registered, so configs must hold two edges
  wire disp_on = DISPLAY_ACTIVATE && !STANDBY_MODE && !MODULE_STANDBY;
  wire stat    = !DUTY_SELECT_HI && !DUTY_SELECT_LO;
  wire half    = !DUTY_SELECT_HI && DUTY_SELECT_LO;

  // activation on the subclock path, then the scan runs with no start command
  sequence s_on;
    $rose(DISPLAY_ACTIVATE) && !STANDBY_MODE && !MODULE_STANDBY && !FRAME_CLOCK_SELECT[3];
  endsequence
  sequence s_sys_gone;
    (disp_on && FRAME_CLOCK_SELECT[3] && !SYS_CLOCK_RUN) [*3];
  endsequence

  // reset itself is the cause here, so this one is not disabled by it
  AST_RESET: assert property (disable iff (1'b0) RST |=> COM_LEVEL == 12'h000 &&
    SEG_DRIVE_EN == 32'h00000000 && !ALTERNATION && !DRIVE_POWER_ON && !DISPLAY_RUNNING)
    else $error("outputs not cleared after reset");
  AST_ACT_OFF: assert property (!DISPLAY_ACTIVATE |=> !DISPLAY_RUNNING && !DRIVE_POWER_ON)
    else $error("display active while activate low");
  AST_STANDBY: assert property (STANDBY_MODE |=> !DISPLAY_RUNNING && !DRIVE_POWER_ON)
    else $error("display or power on in standby");
  AST_MOD_STBY: assert property (MODULE_STANDBY |=> !DISPLAY_RUNNING)
    else $error("display running in module standby");
  AST_NO_SYS: assert property (FRAME_CLOCK_SELECT[3] && !SYS_CLOCK_RUN |=> !DISPLAY_RUNNING)
    else $error("system path running without its clock");
  AST_FROZEN: assert property (s_sys_gone |-> $stable(ALTERNATION))
    else $error("alternation moved with no clock");
  AST_AUTO_START: assert property (s_on |=> DISPLAY_RUNNING)
    else $error("scan did not start after activation");
  AST_BOOST_STAT: assert property ((COMMON_DRIVE_BOOST && stat) [*2] |->
    COM_LEVEL[2:0] == COM_LEVEL[5:3] && COM_LEVEL[2:0] == COM_LEVEL[8:6] &&
    COM_LEVEL[2:0] == COM_LEVEL[11:9]) else $error("boosted static commons differ");
  AST_BOOST_HALF: assert property ((COMMON_DRIVE_BOOST && half) [*2] |->
    COM_LEVEL[2:0] == COM_LEVEL[5:3] && COM_LEVEL[8:6] == COM_LEVEL[11:9])
    else $error("boosted half commons not paired");
  AST_SEG_NONE: assert property ((SEGMENT_SELECT == 4'h0) [*2] |-> SEG_DRIVE_EN == 32'h0)
    else $error("segment driven with none selected");
  AST_SEG_TOP: assert property ((SEGMENT_SELECT == 4'h3) [*2] |-> SEG_DRIVE_EN[31:12] == 20'h0)
    else $error("unselected segment driven");
endmodule

bind sldc_drive sldc_drive_properties u_props (.*);

// *** test/sldc_panel_model.sv ***
// sldc_panel_model: glass panel cell between common 0 and segment 0.
// assumes level codes of the drive block and one sample per clock.
`timescale 1ns/1ps

module sldc_panel_model (
  input wire                 CLK,
  input wire [2:0]           COM0,
  input wire [2:0]           SEG0,
  input wire                 ALTERNATION,
  output logic signed [31:0] last_dc
);
  logic signed [31:0] acc = 0;
  logic               m_d = 1'b0;

  // code to sixths of the drive supply; mid sits between the two taps
  function automatic int volts(input logic [2:0] c);
    case (c)
      3'h1: return 2;
      3'h2: return 4;
      3'h3: return 6;
      3'h4: return 3;
      default: return 0;
    endcase
  endfunction

  // net charge over one full alternation period; nonzero means dc on the glass
  always @(posedge CLK) begin
    m_d <= ALTERNATION;
    if (ALTERNATION && !m_d) begin
      last_dc <= acc;
      acc <= volts(COM0) - volts(SEG0);
    end else
      acc <= acc + volts(COM0) - volts(SEG0);
  end
endmodule

// *** test/sldc_drive_bench.sv ***
// sldc_drive_bench: self-checking bench of the segment lcd drive block.
// assumes the subclock ticks every other cycle and the panel model on pin 0.
`timescale 1ns/1ps

module sldc_drive_bench;
  typedef struct packed {
    logic [1:0] dty;
    logic bst, d;
    logic [2:0] c0a, c0b, c1a, c1b, sa, sb;
  } sldc_row_t;
  logic CLK, RST, COMMON_DRIVE_BOOST, DUTY_SELECT_HI, DUTY_SELECT_LO, WAVEFORM_TYPE_SELECT;
  logic DISPLAY_ACTIVATE, DISPLAY_DATA_SHOW, DRIVE_POWER_SWITCH, SYS_CLOCK_RUN;
  logic SUB_CLOCK_TICK, STANDBY_MODE, MODULE_STANDBY, RAM_WRITE, RAM_WORD;
  logic [3:0] SEGMENT_SELECT, FRAME_CLOCK_SELECT, RAM_ADDR, COM_DRIVE_EN;
  logic [15:0] RAM_WDATA, RAM_RDATA;
  logic [11:0] COM_LEVEL;
  logic [95:0] SEG_LEVEL;
  logic [31:0] SEG_DRIVE_EN;
  logic ALTERNATION, DRIVE_POWER_ON, DISPLAY_RUNNING;
  logic signed [31:0] last_dc;
  int fail_count = 0, samples_checked = 0, n;
  // duty, boost, data, com0 m0/m1, com1 m0/m1, seg0 m0/m1, all sampled in row 0
  sldc_row_t rows [6] = '{'{2'h0, 1'h1, 1'h1, 3'h3, 3'h0, 3'h3, 3'h0, 3'h0, 3'h3},
    '{2'h0, 1'h1, 1'h0, 3'h3, 3'h0, 3'h3, 3'h0, 3'h3, 3'h0},
    '{2'h1, 1'h0, 1'h1, 3'h3, 3'h0, 3'h4, 3'h4, 3'h0, 3'h3},
    '{2'h1, 1'h1, 1'h0, 3'h3, 3'h0, 3'h3, 3'h0, 3'h3, 3'h0},
    '{2'h2, 1'h0, 1'h1, 3'h3, 3'h0, 3'h1, 3'h2, 3'h0, 3'h3},
    '{2'h3, 1'h0, 1'h0, 3'h3, 3'h0, 3'h1, 3'h2, 3'h2, 3'h1}};
  // alternation half periods: sub /1 A, sub /1 B, system /2 B, sub /4 B
  logic [3:0] fcs [4] = '{4'h0, 4'h0, 4'h8, 4'h2};
  int span [4] = '{512, 128, 256, 512};

  sldc_drive dut (.*);
  sldc_panel_model panel (.CLK(CLK), .COM0(COM_LEVEL[2:0]), .SEG0(SEG_LEVEL[2:0]),
    .ALTERNATION(ALTERNATION), .last_dc(last_dc));

  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  // subclock pulse every other cycle, always launched just after the edge
  always @(posedge CLK) SUB_CLOCK_TICK <= #1 (SUB_CLOCK_TICK !== 1'b1);

  task cyc(input int k);
    repeat (k) @(posedge CLK);
    #1;
  endtask
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task results;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // bounded poll; running out is a mismatch and ends the run
  task wait_m(input logic v);
    for (n = 0; n < 3000 && ALTERNATION !== v; n++) cyc(1);
    if (ALTERNATION !== v) begin
      check("alternation wait", ALTERNATION, v);
      results();
    end
  endtask
  // bounded poll with the system clock at half rate, as in medium speed; running out just returns
  task wait_half(input logic v);
    for (n = 0; n < 3000 && ALTERNATION !== v; n++) begin
      SYS_CLOCK_RUN = ~SYS_CLOCK_RUN;
      cyc(1);
    end
  endtask
  task do_reset;
    RST = 1'b1;
    DISPLAY_ACTIVATE = 1'b0;
    cyc(6);
    RST = 1'b0;
  endtask
  // strobe is left high so back-to-back calls assign it once per step
  task ram_wr(input logic w, input logic [3:0] a, input logic [15:0] d);
    RAM_WRITE = 1'b1;
    RAM_WORD = w;
    RAM_ADDR = a;
    RAM_WDATA = d;
    cyc(1);
  endtask

  initial begin
    {RST, COMMON_DRIVE_BOOST, DUTY_SELECT_HI, DUTY_SELECT_LO, WAVEFORM_TYPE_SELECT} = 5'h00;
    {DISPLAY_ACTIVATE, STANDBY_MODE, MODULE_STANDBY, RAM_WRITE, RAM_WORD} = 5'h00;
    {DISPLAY_DATA_SHOW, DRIVE_POWER_SWITCH, SYS_CLOCK_RUN} = 3'h7;
    {SEGMENT_SELECT, FRAME_CLOCK_SELECT, RAM_ADDR, RAM_WDATA} = 28'h8000000;
    do_reset();
    check("com after reset", COM_LEVEL, 32'h0);
    check("seg after reset", {SEG_LEVEL[95:64] | SEG_LEVEL[63:32] | SEG_LEVEL[31:0]}, 0);
    check("rdata after reset", RAM_RDATA, 32'h0);
    check("com enables after reset", COM_DRIVE_EN, 32'h0);
    $display("reset test done");
    foreach (rows[k]) begin
      do_reset();
      check("alternation after reset", ALTERNATION, 0);
      {DUTY_SELECT_HI, DUTY_SELECT_LO} = rows[k].dty;
      COMMON_DRIVE_BOOST = rows[k].bst;
      ram_wr(1'b1, 4'h0, {16{rows[k].d}});
      RAM_WRITE = 1'b0;
      DISPLAY_ACTIVATE = 1'b1;
      cyc(20);
      check("com0 m0", COM_LEVEL[2:0], rows[k].c0a);
      check("com1 m0", COM_LEVEL[5:3], rows[k].c1a);
      check("seg0 m0", SEG_LEVEL[2:0], rows[k].sa);
      check("com enables", COM_DRIVE_EN, (rows[k].bst && !rows[k].dty[1]) ? 4'hF :
        (4'hF >> (2'h3 - rows[k].dty)));
      wait_m(1'b1);
      cyc(4);
      check("com0 m1", COM_LEVEL[2:0], rows[k].c0b);
      check("com1 m1", COM_LEVEL[5:3], rows[k].c1b);
      check("seg0 m1", SEG_LEVEL[2:0], rows[k].sb);
      wait_m(1'b0);
      wait_m(1'b1);
      // the panel sees the new rise one edge after the poll does
      cyc(1);
      check("panel dc", last_dc, 0);
      $display("row %0d done", k);
    end
    // ram byte order, byte merge into a word, odd word address
    ram_wr(1'b1, 4'h2, 16'hABCD);
    ram_wr(1'b0, 4'h3, 16'h0012);
    ram_wr(1'b1, 4'h5, 16'h3456);
    RAM_WRITE = 1'b0;
    RAM_ADDR = 4'h2;
    cyc(2);
    check("rdata word 2", RAM_RDATA, 16'hAB12);
    RAM_ADDR = 4'h4;
    cyc(2);
    check("rdata word 4", RAM_RDATA, 16'h3456);
    $display("ram test done");
    // alternation half period by waveform type and clock path, quarter duty
    for (int k = 0; k < 4; k++) begin
      do_reset();
      {DUTY_SELECT_HI, DUTY_SELECT_LO} = 2'h3;
      FRAME_CLOCK_SELECT = fcs[k];
      WAVEFORM_TYPE_SELECT = (k > 0);
      DISPLAY_ACTIVATE = 1'b1;
      wait_m(1'b1);
      for (n = 0; n < 3000 && ALTERNATION === 1'b1; n++) cyc(1);
      check("alternation half period", n, span[k]);
    end
    // medium speed: half-rate system clock, same /2 divide, so a 512-cycle half period
    do_reset();
    FRAME_CLOCK_SELECT = 4'h8;
    DISPLAY_ACTIVATE = 1'b1;
    wait_half(1'b1);
    wait_half(1'b0);
    check("medium speed half period", n, 512);
    SYS_CLOCK_RUN = 1'b1;
    $display("waveform test done");
    // segment enables, clock presence and power modes
    do_reset();
    SEGMENT_SELECT = 4'h3;
    FRAME_CLOCK_SELECT = 4'h0;
    ram_wr(1'b1, 4'h0, 16'hFFFF);
    RAM_WRITE = 1'b0;
    DISPLAY_ACTIVATE = 1'b1;
    cyc(3);
    check("seg enables 3", SEG_DRIVE_EN, 32'h00000FFF);
    check("power on", DRIVE_POWER_ON, 1);
    check("seg0 shown", SEG_LEVEL[2:0], 32'h0);
    // blanking forces unlit data: quarter duty, m 0 gives mid high
    DISPLAY_DATA_SHOW = 1'b0;
    cyc(2);
    check("seg0 blanked", SEG_LEVEL[2:0], 32'h2);
    DISPLAY_DATA_SHOW = 1'b1;
    SYS_CLOCK_RUN = 1'b0;
    cyc(3);
    check("sub path without sys", DISPLAY_RUNNING, 1);
    FRAME_CLOCK_SELECT = 4'h8;
    cyc(4);
    check("sys path without sys", DISPLAY_RUNNING, 0);
    {FRAME_CLOCK_SELECT, SYS_CLOCK_RUN, STANDBY_MODE} = 6'h03;
    cyc(3);
    check("standby running", DISPLAY_RUNNING, 0);
    check("standby power", DRIVE_POWER_ON, 0);
    {STANDBY_MODE, MODULE_STANDBY} = 2'h1;
    cyc(3);
    check("module standby", DISPLAY_RUNNING, 0);
    {MODULE_STANDBY, SEGMENT_SELECT} = 5'h09;
    cyc(3);
    check("seg enables all", SEG_DRIVE_EN, 32'hFFFFFFFF);
    SEGMENT_SELECT = 4'h0;
    DRIVE_POWER_SWITCH = 1'b0;
    cyc(3);
    check("seg enables none", SEG_DRIVE_EN, 32'h0);
    check("switch off power", DRIVE_POWER_ON, 0);
    DRIVE_POWER_SWITCH = 1'b1;
    DISPLAY_ACTIVATE = 1'b0;
    cyc(3);
    check("off power", DRIVE_POWER_ON, 0);
    $display("mode test done");
    results();
  end
endmodule
